// *** hdl/flash_host.sv ***
// Host controller driving flash strobes for program, query and secure sector access
// Summary of operation
// - Program secure sector with standard unlock and program sequence.
// - Locking issues three-cycle secure entry first; reset pin may stay high.
// - Alternate protect method also follows secure entry sequence.
// - Host issues secure exit sequence before touching main array.
// - Every program begins with the two unlock cycles.
// - Write cycle only with chip and write enable low, output enable high.
// - Query entry writes 98h to address 55h from read mode.
// - Query exit writes the reset command.
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic [2:0]  REQ_OP,
    input  wire logic [11:0] REQ_ADDR,
    input  wire logic [15:0] REQ_DATA,
    input  wire logic        BYTE_MODE,
    input  wire logic        GUARD_OPEN,
    output logic             DONE,
    output logic [15:0]      RD_DATA,
    input  wire logic [4:0]  QRY_INDEX,
    output logic [15:0]      QRY_WORD,
    output logic             SECURE_MODE,
    output logic             QUERY_MODE,
    output logic             CE_N,
    output logic             OE_N,
    output logic             WE_N,
    output logic [11:0]      ADDR,
    output logic [15:0]      DQ_O,
    output logic             DQ_OE,
    input  wire logic [15:0] DQ_I,
    output logic             BOUNDARY_GUARD_ACCEL_INPUT
);
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT, ST_QSCAN,
                              ST_DONE} state_t;
    typedef struct packed {
        state_t      st;
        logic [2:0]  op;
        logic [2:0]  seq;
        logic [2:0]  seq_len;
        logic [2:0]  ph;
        logic        wr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [11:0] addr;
        logic [15:0] dout;
        logic [15:0] din;
        logic [15:0] dq_s1;
        logic [15:0] dq_s2;
        logic [11:0] user_addr;
        logic [15:0] user_data;
        logic        secure;
        logic        query;
        logic [4:0]  qidx;
        logic        qwe;
        logic [15:0] s1;
        logic [15:0] s2;
        logic        done;
    } regs_t;
    regs_t r_reg;
    regs_t r_next;
    logic [15:0] qry_rdata;
    query_store u_store
    (
        .clk   (CLK),
        .we    (r_reg.qwe),
        .waddr (r_reg.qidx),
        .wdata (r_reg.s2),
        .raddr (QRY_INDEX),
        .rdata (qry_rdata)
    );
    // Cycle table of each operation
    function automatic logic [35:0] step(input logic [2:0] op, input logic [2:0] n,
                                         input logic [11:0] ua, input logic [15:0] ud);
        logic [11:0] a;
        logic [15:0] d;
        logic        w;
        a = ua;
        d = ud;
        w = 1'b1;
        case (op)
            flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_SEC_ENTER,
            flash_host_pkg::OP_SEC_EXIT:
            begin
                case (n)
                    3'h0:
                    begin
                        a = `FH_ADDR_UNLOCK1;
                        d = {8'h00, `FH_CMD_UNLOCK1};
                    end
                    3'h1:
                    begin
                        a = `FH_ADDR_UNLOCK2;
                        d = {8'h00, `FH_CMD_UNLOCK2};
                    end
                    3'h2:
                    begin
                        a = `FH_ADDR_UNLOCK1;
                        d = (op == flash_host_pkg::OP_PROGRAM) ? {8'h00, `FH_CMD_PROGRAM} :
                            (op == flash_host_pkg::OP_SEC_ENTER) ? {8'h00, `FH_CMD_SEC_ENTER} :
                            {8'h00, `FH_CMD_SEC_EXIT1};
                    end
                    default:
                    begin
                        if (op == flash_host_pkg::OP_SEC_EXIT)
                        begin
                            a = 12'h000;
                            d = {8'h00, `FH_CMD_SEC_EXIT2};
                        end
                    end
                endcase
            end
            flash_host_pkg::OP_QUERY:
            begin
                a = `FH_ADDR_QUERY;
                d = {8'h00, `FH_CMD_QUERY};
            end
            flash_host_pkg::OP_RESET:
            begin
                d = {8'h00, `FH_CMD_RESET};
            end
            default:
            begin
                w = 1'b0;
            end
        endcase
        step = {w, 3'h0, a, d, 4'h0};
    endfunction
    logic [35:0] cyc;
    always_comb
    begin
        cyc = step(r_reg.op, r_reg.seq, r_reg.user_addr, r_reg.user_data);
        r_next = r_reg;
        r_next.qwe = 1'b0;
        r_next.done = 1'b0;
        // Two-stage capture of the device data bus
        r_next.dq_s1 = DQ_I;
        r_next.dq_s2 = r_reg.dq_s1;
        case (r_reg.st)
            ST_IDLE:
            begin
                r_next.ce_n = 1'b1;
                r_next.oe_n = 1'b1;
                r_next.we_n = 1'b1;
                if (REQ_VALID)
                begin
                    r_next.op = REQ_OP;
                    r_next.user_addr = REQ_ADDR;
                    r_next.user_data = REQ_DATA;
                    r_next.seq = 3'h0;
                    r_next.ph = 3'h0;
                    // Programs, secure entry and secure exit carry unlock cycles
                    case (REQ_OP)
                        flash_host_pkg::OP_PROGRAM: r_next.seq_len = 3'h4;
                        flash_host_pkg::OP_SEC_ENTER: r_next.seq_len = 3'h3;
                        flash_host_pkg::OP_SEC_EXIT: r_next.seq_len = `FH_SEQ_MAX;
                        default: r_next.seq_len = 3'h1;
                    endcase
                    r_next.st = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                r_next.wr = cyc[35];
                r_next.addr = cyc[31:20];
                if (BYTE_MODE && r_reg.op == flash_host_pkg::OP_READ)
                begin
                    r_next.addr = {cyc[30:20], 1'b0};
                end
                r_next.dout = cyc[19:4];
                r_next.ce_n = 1'b0;
                r_next.oe_n = cyc[35];
                r_next.we_n = 1'b1;
                r_next.ph = 3'h0;
                r_next.st = ST_STROBE;
            end
            ST_STROBE:
            begin
                // Write only with chip and write enable low, output enable high
                r_next.we_n = ~r_reg.wr;
                r_next.ph = r_reg.ph + 3'h1;
                if (r_reg.ph == `FH_PH_CYCLES)
                begin
                    r_next.din = r_reg.dq_s2;
                    r_next.st = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                r_next.we_n = 1'b1;
                r_next.oe_n = 1'b1;
                r_next.st = ST_NEXT;
            end
            ST_NEXT:
            begin
                r_next.ce_n = 1'b1;
                r_next.seq = r_reg.seq + 3'h1;
                if (r_reg.seq + 3'h1 < r_reg.seq_len)
                begin
                    r_next.st = ST_SETUP;
                end
                else
                begin
                    case (r_reg.op)
                        flash_host_pkg::OP_SEC_ENTER: r_next.secure = 1'b1;
                        flash_host_pkg::OP_SEC_EXIT: r_next.secure = 1'b0;
                        flash_host_pkg::OP_RESET: r_next.query = 1'b0;
                        default: r_next.secure = r_reg.secure;
                    endcase
                    if (r_reg.op == flash_host_pkg::OP_QUERY)
                    begin
                        // Enter query then scan the table
                        r_next.query = 1'b1;
                        r_next.qidx = 5'h00;
                        r_next.op = flash_host_pkg::OP_READ;
                        r_next.user_addr = `FH_QRY_FIRST;
                        r_next.seq = 3'h0;
                        r_next.seq_len = 3'h1;
                        r_next.st = ST_QSCAN;
                    end
                    else if (r_reg.query && r_reg.op == flash_host_pkg::OP_READ &&
                             r_reg.user_addr >= `FH_QRY_FIRST &&
                             r_reg.user_addr <= `FH_QRY_LAST && r_reg.seq_len == 3'h1 &&
                             r_reg.qidx < `FH_QRY_COUNT && r_reg.st == ST_NEXT &&
                             r_reg.s1 == 16'h0001)
                    begin
                        r_next.st = ST_QSCAN;
                    end
                    else
                    begin
                        r_next.st = ST_DONE;
                    end
                end
            end
            ST_QSCAN:
            begin
                // Stores each word 10h to 26h
                if (r_reg.s1 == 16'h0001)
                begin
                    r_next.s2 = {8'h00, r_reg.din[7:0]};
                    r_next.qwe = 1'b1;
                    r_next.qidx = r_reg.qidx;
                end
                if (r_reg.s1 == 16'h0001 && r_reg.user_addr == `FH_QRY_LAST)
                begin
                    r_next.s1 = 16'h0000;
                    r_next.st = ST_DONE;
                end
                else
                begin
                    if (r_reg.s1 == 16'h0001)
                    begin
                        r_next.user_addr = r_reg.user_addr + 12'h001;
                    end
                    r_next.s1 = 16'h0001;
                    r_next.seq = 3'h0;
                    r_next.st = ST_SETUP;
                end
            end
            ST_DONE:
            begin
                r_next.done = 1'b1;
                r_next.s1 = 16'h0000;
                r_next.st = ST_IDLE;
            end
            default:
            begin
                r_next.st = ST_IDLE;
            end
        endcase
        if (r_reg.qwe)
        begin
            r_next.qidx = r_reg.qidx + 5'h01;
        end
    end
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            r_reg <= '0;
            r_reg.ce_n <= 1'b1;
            r_reg.oe_n <= 1'b1;
            r_reg.we_n <= 1'b1;
            r_reg.st <= ST_IDLE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end
    assign REQ_READY = (r_reg.st == ST_IDLE);
    assign DONE = r_reg.done;
    assign RD_DATA = r_reg.din;
    assign QRY_WORD = qry_rdata;
    assign SECURE_MODE = r_reg.secure;
    assign QUERY_MODE = r_reg.query;
    assign CE_N = r_reg.ce_n;
    assign OE_N = r_reg.oe_n;
    assign WE_N = r_reg.we_n;
    assign ADDR = r_reg.addr;
    assign DQ_O = r_reg.dout;
    assign DQ_OE = r_reg.wr & ~r_reg.ce_n;
    // Guard input high lets the boundary group be programmed; low blocks boundary group
    assign BOUNDARY_GUARD_ACCEL_INPUT = GUARD_OPEN;
    a_write_strobe_ok: assert property (@(posedge CLK) disable iff (SRST)
        !WE_N |-> (!CE_N && OE_N)) else $error("write strobe without chip enable");
    a_bus_turn: assert property (@(posedge CLK) disable iff (SRST)
        (!CE_N && !OE_N) |-> !DQ_OE) else $error("data bus driven during read");
    a_reset_we_high: assert property (@(posedge CLK)
        SRST |=> WE_N) else $error("write enable low after reset");
    a_strobe_width: assert property (@(posedge CLK) disable iff (SRST)
        $fell(WE_N) |-> !WE_N [*3]) else $error("write pulse too short");
    a_query_cmd: assert property (@(posedge CLK) disable iff (SRST)
        ($fell(WE_N) && r_reg.op == flash_host_pkg::OP_QUERY) |->
        (ADDR == `FH_ADDR_QUERY && DQ_O[7:0] == `FH_CMD_QUERY))
        else $error("bad query command");
    a_prog_unlock: assert property (@(posedge CLK) disable iff (SRST)
        ($fell(WE_N) && r_reg.op == flash_host_pkg::OP_PROGRAM && r_reg.seq == 3'h0) |->
        (ADDR == `FH_ADDR_UNLOCK1 && DQ_O[7:0] == `FH_CMD_UNLOCK1))
        else $error("program without unlock");
    a_reset_leaves_q: assert property (@(posedge CLK) disable iff (SRST)
        (r_reg.st == ST_NEXT && r_reg.op == flash_host_pkg::OP_RESET &&
        r_reg.seq_len == 3'h1) |=> !QUERY_MODE) else $error("query kept after reset");
    a_enter_secure: assert property (@(posedge CLK) disable iff (SRST)
        (r_reg.st == ST_NEXT && r_reg.op == flash_host_pkg::OP_SEC_ENTER && r_reg.seq == 3'h2)
        |=> SECURE_MODE) else $error("secure entry not recorded");
    a_exit_secure: assert property (@(posedge CLK) disable iff (SRST)
        (r_reg.st == ST_NEXT && r_reg.op == flash_host_pkg::OP_SEC_EXIT && r_reg.seq == 3'h3)
        |=> !SECURE_MODE) else $error("secure exit not recorded");
endmodule

// *** hdl/flash_host_map.svh ***
// Constants for the flash host controller
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define FH_CMD_QUERY      8'h98
`define FH_ADDR_QUERY     12'h055
`define FH_CMD_RESET      8'hF0
`define FH_CMD_UNLOCK1    8'hAA
`define FH_CMD_UNLOCK2    8'h55
`define FH_ADDR_UNLOCK1   12'h555
`define FH_ADDR_UNLOCK2   12'h2AA
`define FH_CMD_SEC_ENTER  8'h88
`define FH_CMD_SEC_EXIT1  8'h90
`define FH_CMD_SEC_EXIT2  8'h00
`define FH_CMD_PROGRAM    8'hA0
`define FH_QRY_FIRST      12'h010
`define FH_QRY_LAST       12'h026
`define FH_QRY_COUNT      5'h17
`define FH_PH_CYCLES      3'h2
`define FH_SEQ_MAX        3'h4
`endif

// *** hdl/flash_host_pkg.sv ***
// Types for the flash host controller
package flash_host_pkg;
    typedef enum logic [2:0] {OP_PROGRAM, OP_QUERY, OP_RESET, OP_SEC_ENTER, OP_SEC_EXIT,
                              OP_READ} op_t;
endpackage

// *** hdl/query_store.sv ***
// Memory holding query table words read back
`timescale 1ns/1ps
module query_store
(
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [4:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [4:0]  raddr,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:31];
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// *** bench/flash_dev_model.sv ***
// Behavioural flash device answering the host strobes
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_dev_model
#(
    parameter bit SEC_LOCKED = 1'b0
)
(
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [11:0] addr,
    input  wire logic [15:0] din,
    input  wire logic        byte_mode,
    input  wire logic        guard,
    output logic      [15:0] dout
);
    logic [15:0] mem [0:4095];
    logic [15:0] sec [0:127];
    logic [15:0] qry [0:22];
    logic [15:0] last;
    logic [15:0] val;
    logic [11:0] wa;
    int          step;
    bit          qmode;
    bit          smode;
    bit          prog;
    realtime     t_low;
    // Power-up in read mode, normal sector map
    initial
    begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        foreach (sec[i]) sec[i] = 16'hFFFF;
        // Locked variant ships with a serial pattern; values are arbitrary
        if (SEC_LOCKED)
            for (int i = 0; i < 8; i++)
                sec[i] = {8'h5A, i[7:0]};
        qry = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
                16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000,
                16'h0000, 16'h0007, 16'h0007, 16'h000A, 16'h0000, 16'h0001, 16'h0005,
                16'h0004, 16'h0000};
        last = 16'h0000;
        step = 0;
        qmode = 0;
        smode = 0;
        prog = 0;
    end
    // Read path, released bus shows inverse of last value
    always @*
    begin
        wa = byte_mode ? {1'b0, addr[11:1]} : addr;
        if (qmode && wa >= 12'h010 && wa <= 12'h026)
            val = qry[wa - 12'h010];
        else if (smode && wa < 12'h080)
            val = sec[wa[6:0]];
        else
            val = mem[wa];
        if (!ce_n && !oe_n)
            last = val;
    end
    assign dout = (!ce_n && !oe_n) ? val : ~last;
    // Start of each write pulse, for glitch rejection
    always @(negedge we_n)
        t_low = $realtime;
    // Command decode on write strobe release
    always @(posedge we_n)
    begin
        if (!ce_n && oe_n && ($realtime - t_low) >= 3.0)
        begin
            if (prog)
            begin
                prog = 0;
                if (smode)
                begin
                    if (!SEC_LOCKED && addr < 12'h080)
                        sec[addr[6:0]] &= din;
                end
                else if (guard || addr >= 12'h100)
                    mem[addr] &= din;
            end
            else if (din[7:0] == `FH_CMD_RESET)
            begin
                qmode = 0;
                step = 0;
            end
            else if (din[7:0] == `FH_CMD_QUERY && addr == `FH_ADDR_QUERY)
                qmode = 1;
            else if (step == 0 && din[7:0] == `FH_CMD_UNLOCK1 && addr == `FH_ADDR_UNLOCK1)
                step = 1;
            else if (step == 1 && din[7:0] == `FH_CMD_UNLOCK2 && addr == `FH_ADDR_UNLOCK2)
                step = 2;
            else if (step == 2)
            begin
                step = (din[7:0] == `FH_CMD_SEC_EXIT1) ? 3 : 0;
                prog = (din[7:0] == `FH_CMD_PROGRAM);
                if (din[7:0] == `FH_CMD_SEC_ENTER)
                    smode = 1;
            end
            else if (step == 3)
            begin
                step = 0;
                if (din[7:0] == `FH_CMD_SEC_EXIT2)
                    smode = 0;
            end
            else
                step = 0;
        end
    end
endmodule

// *** bench/flash_write_guard_and_cfi_query_tb_top.sv ***
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_write_guard_and_cfi_query_tb_top;
    logic        clk, srst, req_valid, req_ready, byte_mode, guard_open, done;
    logic        secure_mode, query_mode, ce_n, oe_n, we_n, dq_oe, guard_pin;
    logic [2:0]  req_op;
    logic [11:0] req_addr, addr;
    logic [15:0] req_data, rd_data, qry_word, dq_o, dq_i;
    logic [15:0] dq_open, dq_lk;
    logic        use_lk;
    logic [4:0]  qry_index;
    logic [15:0] qry_exp [0:22];
    int          num_errors, total_checks, cycles;
    flash_host dut (.CLK(clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .BYTE_MODE(byte_mode),
        .GUARD_OPEN(guard_open), .DONE(done), .RD_DATA(rd_data), .QRY_INDEX(qry_index),
        .QRY_WORD(qry_word), .SECURE_MODE(secure_mode), .QUERY_MODE(query_mode),
        .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .DQ_O(dq_o), .DQ_OE(dq_oe),
        .DQ_I(dq_i), .BOUNDARY_GUARD_ACCEL_INPUT(guard_pin));
    flash_dev_model #(.SEC_LOCKED(1'b0)) dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .din(dq_o), .byte_mode(byte_mode), .guard(guard_pin), .dout(dq_open));
    // Factory locked twin sees the same strobes
    flash_dev_model #(.SEC_LOCKED(1'b1)) dev_lk (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .din(dq_o), .byte_mode(byte_mode), .guard(guard_pin), .dout(dq_lk));
    assign dq_i = use_lk ? dq_lk : dq_open;
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done;
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, held until taken, then wait for completion
    task automatic run_op(input logic [2:0] op, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        req_op = op;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 req_valid = 1'b0;
        while (done !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("done", 16'h0001, {15'h0000, done});
    endtask
    task automatic test_query(input logic bm);
        byte_mode = bm;
        run_op(flash_host_pkg::OP_QUERY, 12'h000, 16'h0000);
        check("query_mode", 16'h0001, {15'h0000, query_mode});
        for (int i = 0; i < 23; i++)
        begin
            qry_index = i[4:0];
            @(posedge clk);
            #1 check("qry_word", qry_exp[i], qry_word);
        end
        run_op(flash_host_pkg::OP_READ, 12'h011, 16'h0000);
        check("query read", 16'h0052, rd_data);
        run_op(flash_host_pkg::OP_RESET, 12'h000, 16'h0000);
        check("query_mode", 16'h0000, {15'h0000, query_mode});
        run_op(flash_host_pkg::OP_READ, 12'h011, 16'h0000);
        check("array read", 16'hFFFF, rd_data);
        byte_mode = 1'b0;
    endtask
    task automatic test_program;
        run_op(flash_host_pkg::OP_PROGRAM, 12'h200, 16'h1234);
        run_op(flash_host_pkg::OP_READ, 12'h200, 16'h0000);
        check("programmed", 16'h1234, rd_data);
        guard_open = 1'b0;
        #1 check("guard pin", 16'h0000, {15'h0000, guard_pin});
        run_op(flash_host_pkg::OP_PROGRAM, 12'h010, 16'h0F0F);
        run_op(flash_host_pkg::OP_READ, 12'h010, 16'h0000);
        check("guarded", 16'hFFFF, rd_data);
        guard_open = 1'b1;
        run_op(flash_host_pkg::OP_PROGRAM, 12'h010, 16'h0F0F);
        run_op(flash_host_pkg::OP_READ, 12'h010, 16'h0000);
        check("unguarded", 16'h0F0F, rd_data);
    endtask
    task automatic test_secure;
        run_op(flash_host_pkg::OP_SEC_ENTER, 12'h000, 16'h0000);
        check("secure_mode", 16'h0001, {15'h0000, secure_mode});
        run_op(flash_host_pkg::OP_PROGRAM, 12'h003, 16'hA5A5);
        run_op(flash_host_pkg::OP_READ, 12'h003, 16'h0000);
        check("secure word", 16'hA5A5, rd_data);
        run_op(flash_host_pkg::OP_SEC_EXIT, 12'h000, 16'h0000);
        check("secure_mode", 16'h0000, {15'h0000, secure_mode});
        run_op(flash_host_pkg::OP_READ, 12'h003, 16'h0000);
        check("main word", 16'hFFFF, rd_data);
    endtask
    task automatic test_locked;
        use_lk = 1'b1;
        run_op(flash_host_pkg::OP_SEC_ENTER, 12'h000, 16'h0000);
        run_op(flash_host_pkg::OP_READ, 12'h002, 16'h0000);
        check("serial word", 16'h5A02, rd_data);
        run_op(flash_host_pkg::OP_PROGRAM, 12'h002, 16'h0000);
        run_op(flash_host_pkg::OP_READ, 12'h002, 16'h0000);
        check("locked word", 16'h5A02, rd_data);
        run_op(flash_host_pkg::OP_SEC_EXIT, 12'h000, 16'h0000);
        check("secure_mode", 16'h0000, {15'h0000, secure_mode});
    endtask
    initial
    begin
        qry_exp = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
                    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000,
                    16'h0000, 16'h0007, 16'h0007, 16'h000A, 16'h0000, 16'h0001, 16'h0005,
                    16'h0004, 16'h0000};
        num_errors = 0;
        total_checks = 0;
        cycles = 0;
        srst = 1'b1;
        req_valid = 1'b0;
        req_op = 3'h5;
        req_addr = 12'h000;
        req_data = 16'h0000;
        byte_mode = 1'b0;
        guard_open = 1'b1;
        use_lk = 1'b0;
        qry_index = 5'h00;
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        @(posedge clk);
        #1 test_query(1'b0);
        test_query(1'b1);
        test_program();
        test_secure();
        test_locked();
        test_done();
    end
endmodule
